// ---- hw/sxu_pkg.sv ----
package sxu_pkg;

    typedef enum logic [2:0] {
        SXU_IDLE = 3'b000,
        SXU_DECODE = 3'b001,
        SXU_READ = 3'b010,
        SXU_PROC = 3'b011,
        SXU_WRITE = 3'b100
    } sxu_state_t;

    // Opcode fields of the instruction word
    localparam logic [7:0] SXU_OP_LIT = 8'h08;
    localparam logic [5:0] SXU_OP_FILE = 6'h17;
    localparam int SXU_D_BIT = 9;
    localparam int SXU_A_BIT = 8;
    localparam int SXU_ACC_SPLIT_BIT = 7;

    // Access bank: low half of bank 0, high half of the top bank
    localparam logic [3:0] SXU_ACC_LOW_BANK = 4'h0;
    localparam logic [3:0] SXU_ACC_HIGH_BANK = 4'hf;

    // Flag positions in the status register
    localparam int SXU_FLG_C = 0;
    localparam int SXU_FLG_DC = 1;
    localparam int SXU_FLG_Z = 2;
    localparam int SXU_FLG_OV = 3;
    localparam int SXU_FLG_N = 4;

    // Register offsets
    localparam logic [1:0] SXU_REG_W = 2'h0;
    localparam logic [1:0] SXU_REG_BSR = 2'h1;
    localparam logic [1:0] SXU_REG_FLAGS = 2'h2;
    localparam logic [1:0] SXU_REG_STATE = 2'h3;

    // Values after reset
    localparam logic [7:0] SXU_W_RST = 8'h00;
    localparam logic [3:0] SXU_BSR_RST = 4'h0;
    localparam logic [4:0] SXU_FLAGS_RST = 5'h00;

    // Cycles from instruction taken to done pulse
    localparam int SXU_DONE_LAT = 5;

endpackage : sxu_pkg

// ---- hw/sxu_subtract_unit.sv ----
// Overview of operation
// - The literal opcode computes the 8-bit immediate minus W and writes the result to W.
// - The file opcode computes the addressed file register minus W, address in the low instruction byte.
// - The file result goes to W when the destination bit is 0 and back to the file register when it is 1.
// - The bank-access bit 0 forces the access bank, 1 uses the bank select register.
// - Both opcodes update N, OV, C, DC and Z, with C cleared on a borrow.
// - A zero result sets Z and C and clears N; a nonzero result clears Z.
// - A negative result wraps to 8-bit two's complement, clears C and sets N to bit 7 of the wrapped result.
// - The literal opcode runs decode, read literal, process, write W in one four-phase cycle.
// - The file opcode runs decode, read file, process, write destination in one four-phase cycle.
module sxu_subtract_unit
    import sxu_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    output logic instr_ready,
    output logic instr_done,
    output logic instr_bad,
    output logic [11:0] file_addr,
    output logic file_rd,
    input wire logic [7:0] file_rdata,
    output logic file_wr,
    output logic [7:0] file_wdata,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [7:0] working_reg,
    output logic [4:0] status_flags
);

    typedef struct packed {
        sxu_state_t st;
        logic [15:0] ir;
        logic [7:0] w;
        logic [3:0] bank_select_register;
        logic [4:0] flags;
        logic [4:0] nf;
        logic [7:0] res;
        logic [11:0] faddr;
        logic frd;
        logic fwr;
        logic [7:0] fwdata;
        logic ready;
        logic done;
        logic bad;
        logic [7:0] rdata;
    } sxu_regs_t;

    sxu_regs_t q;
    sxu_regs_t d;

    logic is_lit;
    logic is_file;
    logic to_file;
    logic [7:0] op_src;
    logic [8:0] diff9;
    logic [4:0] nib5;
    logic [7:0] diff;
    logic ovf;

    assign is_lit = (q.ir[15:8] == SXU_OP_LIT);
    assign is_file = (q.ir[15:10] == SXU_OP_FILE);
    assign to_file = is_file && q.ir[SXU_D_BIT];

    // Operand: immediate, or file data returned the cycle after the read
    assign op_src = is_lit ? q.ir[7:0] : file_rdata;
    // Minuend plus inverted W plus one; bit 8 is the no-borrow carry
    assign diff9 = {1'b0, op_src} + {1'b0, ~q.w} + 9'h001;
    assign nib5 = {1'b0, op_src[3:0]} + {1'b0, ~q.w[3:0]} + 5'h01;
    assign diff = diff9[7:0];
    assign ovf = (op_src[7] != q.w[7]) && (diff[7] != op_src[7]);

    always_comb begin
        d = q;
        d.done = 1'b0;
        d.frd = 1'b0;
        d.fwr = 1'b0;
        d.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                SXU_REG_W: d.rdata = q.w;
                SXU_REG_BSR: d.rdata = {4'h0, q.bank_select_register};
                SXU_REG_FLAGS: d.rdata = {3'h0, q.flags};
                SXU_REG_STATE: d.rdata = {3'h0, q.ready, q.bad, q.st};
                default: d.rdata = 8'h00;
            endcase
        end
        if (reg_wr) begin
            case (reg_addr)
                SXU_REG_W: d.w = reg_wdata;
                SXU_REG_BSR: d.bank_select_register = reg_wdata[3:0];
                SXU_REG_FLAGS: d.flags = reg_wdata[4:0];
                default: d.w = d.w;
            endcase
        end
        case (q.st)
            SXU_IDLE: begin
                if (instr_valid) begin
                    d.ir = instr_word;
                    d.ready = 1'b0;
                    d.bad = 1'b0;
                    d.st = SXU_DECODE;
                end
            end
            SXU_DECODE: begin
                if (is_lit || is_file) begin
                    if (!q.ir[SXU_A_BIT]) begin
                        d.faddr = {(q.ir[SXU_ACC_SPLIT_BIT] ? SXU_ACC_HIGH_BANK : SXU_ACC_LOW_BANK),
                                   q.ir[7:0]};
                    end else begin
                        d.faddr = {q.bank_select_register, q.ir[7:0]};
                    end
                    d.frd = is_file;
                    d.st = SXU_READ;
                end else begin
                    d.bad = 1'b1;
                    d.ready = 1'b1;
                    d.done = 1'b1;
                    d.st = SXU_IDLE;
                end
            end
            SXU_READ: begin
                d.st = SXU_PROC;
            end
            SXU_PROC: begin
                d.res = diff;
                d.fwdata = diff;
                d.fwr = to_file;
                d.nf[SXU_FLG_C] = diff9[8];
                d.nf[SXU_FLG_DC] = nib5[4];
                d.nf[SXU_FLG_Z] = (diff == 8'h00);
                d.nf[SXU_FLG_OV] = ovf;
                d.nf[SXU_FLG_N] = diff[7];
                d.st = SXU_WRITE;
            end
            SXU_WRITE: begin
                if (!to_file) begin
                    d.w = q.res;
                end
                d.flags = q.nf;
                d.ready = 1'b1;
                d.done = 1'b1;
                d.st = SXU_IDLE;
            end
            default: begin
                d.st = SXU_IDLE;
                d.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{
                st: SXU_IDLE,
                ir: 16'h0000,
                w: SXU_W_RST,
                bank_select_register: SXU_BSR_RST,
                flags: SXU_FLAGS_RST,
                nf: SXU_FLAGS_RST,
                res: 8'h00,
                faddr: 12'h000,
                frd: 1'b0,
                fwr: 1'b0,
                fwdata: 8'h00,
                ready: 1'b1,
                done: 1'b0,
                bad: 1'b0,
                rdata: 8'h00
            };
        end else begin
            q <= d;
        end
    end

    assign instr_ready = q.ready;
    assign instr_done = q.done;
    assign instr_bad = q.bad;
    assign file_addr = q.faddr;
    assign file_rd = q.frd;
    assign file_wr = q.fwr;
    assign file_wdata = q.fwdata;
    assign reg_rdata = q.rdata;
    assign working_reg = q.w;
    assign status_flags = q.flags;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_lit_result: assert property ((q.st == SXU_WRITE) && is_lit |=> q.w == $past(q.ir[7:0]) - $past(q.w, 3))
        else $error("literal result wrong");

    a_file_result: assert property ((q.st == SXU_PROC) && is_file |=> q.fwdata == $past(file_rdata) - $past(q.w))
        else $error("file result wrong");

    a_dest_file: assert property ((q.st == SXU_WRITE) && is_file |-> file_wr == q.ir[SXU_D_BIT])
        else $error("destination routing wrong");

    a_bank_access: assert property ((q.st == SXU_DECODE) && is_file && !q.ir[SXU_A_BIT]
        |=> file_rd && file_addr[11:8] == ($past(q.ir[7]) ? SXU_ACC_HIGH_BANK : SXU_ACC_LOW_BANK))
        else $error("access bank not forced");

    a_bank_bsr: assert property ((q.st == SXU_DECODE) && is_file && q.ir[SXU_A_BIT]
        |=> file_addr == {$past(q.bank_select_register), $past(q.ir[7:0])})
        else $error("bank select not used");

    a_zero_flags: assert property ((q.st == SXU_WRITE) && q.res == 8'h00
        |=> status_flags[SXU_FLG_Z] && status_flags[SXU_FLG_C] && !status_flags[SXU_FLG_N])
        else $error("zero flags wrong");

    a_nonzero_z: assert property ((q.st == SXU_WRITE) && q.res != 8'h00 |=> !status_flags[SXU_FLG_Z])
        else $error("Z set on nonzero");

    a_borrow_clears: assert property ((q.st == SXU_PROC) && op_src < q.w
        |=> ##1 !status_flags[SXU_FLG_C] && status_flags[SXU_FLG_N] == $past(q.res[7]))
        else $error("borrow flags wrong");

    a_neg_sets_n: assert property ((q.st == SXU_WRITE) && q.res[7] |=> status_flags[SXU_FLG_N])
        else $error("N not set");

    a_one_cycle: assert property ((q.st == SXU_IDLE) && instr_valid
        ##1 (is_lit || is_file) |=> ##2 (q.st == SXU_WRITE) ##1 instr_done && instr_ready)
        else $error("instruction cycle length wrong");

    a_ovf_dc: assert property ((q.st == SXU_PROC)
        |=> ##1 status_flags[SXU_FLG_OV] == $past(ovf, 2) && status_flags[SXU_FLG_DC] == $past(nib5[4], 2))
        else $error("OV or DC wrong");

    // Handshake and phase sequencing
    a_done_pulse: assert property (instr_done |=> !instr_done)
        else $error("done longer than one cycle");

    a_frd_pulse: assert property (file_rd |=> !file_rd)
        else $error("file read longer than one cycle");

    a_fwr_pulse: assert property (file_wr |=> !file_wr)
        else $error("file write longer than one cycle");

    a_lit_no_read: assert property ((q.st == SXU_READ) && is_lit |-> !file_rd)
        else $error("literal opcode read a file register");

    a_lit_no_write: assert property ((q.st == SXU_WRITE) && is_lit |-> !file_wr)
        else $error("literal opcode wrote a file register");

    a_read_phase: assert property ((q.st == SXU_READ) && is_file |-> file_rd)
        else $error("file read missing in read phase");

    a_ready_busy: assert property ((q.st != SXU_IDLE) |-> !instr_ready)
        else $error("ready while busy");

    a_ready_idle: assert property ((q.st == SXU_IDLE) |-> instr_ready)
        else $error("not ready while idle");

    a_done_ready: assert property (instr_done |-> instr_ready)
        else $error("done without ready");

    a_take_decode: assert property ((q.st == SXU_IDLE) && instr_valid |=> q.st == SXU_DECODE)
        else $error("offered word not taken");

    a_decode_read: assert property ((q.st == SXU_DECODE) && (is_lit || is_file) |=> q.st == SXU_READ)
        else $error("decode not followed by read");

    a_read_proc: assert property ((q.st == SXU_READ) |=> q.st == SXU_PROC)
        else $error("read not followed by process");

    a_proc_write: assert property ((q.st == SXU_PROC) |=> q.st == SXU_WRITE)
        else $error("process not followed by write");

    a_write_idle: assert property ((q.st == SXU_WRITE) |=> (q.st == SXU_IDLE) && instr_done)
        else $error("write phase did not finish");

    a_bad_opcode: assert property ((q.st == SXU_DECODE) && !is_lit && !is_file
        |=> instr_bad && instr_done && (q.st == SXU_IDLE))
        else $error("unknown opcode not flagged");

    a_bad_keeps_w: assert property ((q.st == SXU_DECODE) && !is_lit && !is_file && !reg_wr
        |=> working_reg == $past(working_reg))
        else $error("unknown opcode changed W");

    // Result routing and flags
    a_fwdata_result: assert property ((q.st == SXU_WRITE) |-> file_wdata == q.res)
        else $error("file write data is not the result");

    a_w_dest: assert property ((q.st == SXU_WRITE) && !to_file |=> working_reg == $past(q.res))
        else $error("W not written with result");

    a_file_keeps_w: assert property ((q.st == SXU_WRITE) && to_file && !reg_wr
        |=> working_reg == $past(working_reg))
        else $error("W changed on file destination");

    a_flags_commit: assert property ((q.st == SXU_WRITE) |=> status_flags == $past(q.nf))
        else $error("flags not committed");

    a_carry_nb: assert property ((q.st == SXU_PROC) |=> ##1 status_flags[SXU_FLG_C] == $past(diff9[8], 2))
        else $error("carry not the no-borrow bit");

    a_neg_msb: assert property ((q.st == SXU_WRITE) |=> status_flags[SXU_FLG_N] == $past(q.res[7]))
        else $error("N not the result sign");

    a_pos_no_n: assert property ((q.st == SXU_WRITE) && !q.res[7] |=> !status_flags[SXU_FLG_N])
        else $error("N set on positive result");

    a_lit_operand: assert property ((q.st == SXU_PROC) && is_lit |-> op_src == q.ir[7:0])
        else $error("literal operand wrong");

    a_addr_low: assert property ((q.st == SXU_DECODE) && is_file |=> file_addr[7:0] == $past(q.ir[7:0]))
        else $error("file address low byte wrong");

    // Register port
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero without read");

    a_read_w: assert property (reg_rd && (reg_addr == SXU_REG_W) |=> reg_rdata == $past(q.w))
        else $error("W read back wrong");

endmodule : sxu_subtract_unit

// ---- testbench/tb_top.sv ----
module tb_top
    import sxu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, instr_valid, instr_ready, instr_done, instr_bad;
    logic file_rd, file_wr, reg_wr, reg_rd;
    logic [15:0] instr_word;
    logic [11:0] file_addr, wadr;
    logic [7:0] file_rdata, file_wdata, reg_wdata, reg_rdata, working_reg, wdat;
    logic [1:0] reg_addr;
    logic [4:0] status_flags;
    int n_fail = 0, n_compared = 0, lat, nrd, nwr, cyc = 0;
    logic [7:0] lw[6] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h80, 8'hff};
    logic [7:0] lk[6] = '{8'h02, 8'h02, 8'h02, 8'hff, 8'h7f, 8'h00};
    logic [3:0] fb[4] = '{4'h5, 4'h5, 4'h5, 4'ha};
    logic [3:0] fd = 4'b0101;
    logic [3:0] fa = 4'b1001;
    logic [7:0] fo[4] = '{8'h3c, 8'h90, 8'h10, 8'hff};
    logic [7:0] fr[4] = '{8'h03, 8'h02, 8'h01, 8'h07};
    logic [7:0] fw[4] = '{8'h02, 8'h02, 8'h02, 8'h09};

    sxu_subtract_unit sxu_subtract_unit_i (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_ready(instr_ready), .instr_done(instr_done), .instr_bad(instr_bad),
        .file_addr(file_addr), .file_rd(file_rd), .file_rdata(file_rdata), .file_wr(file_wr),
        .file_wdata(file_wdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .working_reg(working_reg), .status_flags(status_flags));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Flags of a - b: N, OV, Z, DC, C
    function automatic logic [4:0] ef(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] d;
        logic [4:0] l;
        d = {1'b0, a} - {1'b0, b};
        l = {1'b0, a[3:0]} - {1'b0, b[3:0]};
        return {d[7], (a[7] != b[7]) && (d[7] != a[7]), d[7:0] == 8'h00, ~l[4], ~d[8]};
    endfunction : ef

    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : reg_write

    task automatic reg_chk(input logic [1:0] a, input logic [7:0] e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        chk("reg_rdata", e, reg_rdata);
    endtask : reg_chk

    // Offers one word, serves the file read, records the transfer
    task automatic run(input logic [15:0] w, input logic [7:0] d);
        int n;
        instr_valid <= 1'b1;
        instr_word <= w;
        @(posedge clk);
        instr_valid <= 1'b0;
        n = 0; nrd = 0; nwr = 0; lat = -1;
        while (lat < 0 && n < 20) begin
            @(posedge clk);
            n++;
            if (file_rd === 1'b1) begin
                nrd++;
                wadr = file_addr;
            end
            if (file_wr === 1'b1) begin
                nwr++;
                wdat = file_wdata;
            end
            if (instr_done === 1'b1) lat = n;
            file_rdata <= (file_rd === 1'b1) ? d : ~d;
        end
    endtask : run

    task automatic t_lit();
        for (int i = 0; i < 6; i++) begin
            reg_write(SXU_REG_W, lw[i]);
            run({SXU_OP_LIT, lk[i]}, 8'h00);
            chk("lit_w", 8'(lk[i] - lw[i]), working_reg);
            chk("lit_flags", ef(lk[i], lw[i]), status_flags);
            chk("lit_lat", SXU_DONE_LAT, 12'(lat));
            chk("lit_file", 12'h000, 12'(nrd + nwr));
        end
        reg_chk(SXU_REG_W, 8'h01);
    endtask : t_lit

    task automatic t_file();
        logic [11:0] ea;
        logic [7:0] res;
        for (int i = 0; i < 4; i++) begin
            reg_write(SXU_REG_BSR, {4'h0, fb[i]});
            reg_write(SXU_REG_W, fw[i]);
            run({SXU_OP_FILE, fd[i], fa[i], fo[i]}, fr[i]);
            ea = fa[i] ? {fb[i], fo[i]} : {fo[i][7] ? SXU_ACC_HIGH_BANK : SXU_ACC_LOW_BANK, fo[i]};
            res = fr[i] - fw[i];
            chk("file_addr", ea, wadr);
            chk("file_wr", {11'h000, fd[i]}, 12'(nwr));
            chk("file_res", res, fd[i] ? wdat : working_reg);
            chk("file_w", fd[i] ? fw[i] : res, working_reg);
            chk("file_flags", ef(fr[i], fw[i]), status_flags);
            chk("file_lat", SXU_DONE_LAT, 12'(lat));
            chk("file_rd", 12'h001, 12'(nrd));
        end
    endtask : t_file

    task automatic t_bad();
        run(16'hffff, 8'h00);
        chk("bad_lat", 12'h002, 12'(lat));
        chk("bad_flag", 12'h001, instr_bad);
        chk("bad_w", 12'h0fe, working_reg);
        reg_write(SXU_REG_STATE, 8'hff);
        reg_chk(SXU_REG_STATE, 8'h18);
        reg_write(SXU_REG_FLAGS, 8'h15);
        reg_chk(SXU_REG_FLAGS, 8'h15);
        run({SXU_OP_LIT, 8'h05}, 8'h00);
        chk("bad_clear", 12'h000, instr_bad);
        chk("lit_w", 12'h007, working_reg);
    endtask : t_bad

    task automatic finish_test();
        $display("compared %0d n_fail %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            finish_test();
        end
    end

    initial begin
        rst_b = 1'b0;
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        file_rdata = 8'h00;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk("rst_ready", 12'h001, instr_ready);
        chk("rst_w", SXU_W_RST, working_reg);
        chk("rst_flags", SXU_FLAGS_RST, status_flags);
        t_lit();
        t_file();
        t_bad();
        finish_test();
    end
endmodule : tb_top
